// [cssd_pkg.sv]
// constants and types of the clock source select and division block
// Behaviour
// RULE_01: main clock takes any oscillator but the module one, divided 1..128.
// RULE_02: sub-main clock is the main clock divided by 1, 2, 4 or 8.
// RULE_03: auxiliary clock comes from the crystal or the rc oscillator.
// RULE_04: loop reference clock is the internal rc or the crystal clock.
// RULE_05: crystal failure swaps in the rc clock so consumers keep running; counter code 10 is gated low instead of swapped.
// RULE_06: cpu, memories, checksum and ports run on main clock, no select.
// RULE_07: timer select: 10 sub-main, 01 auxiliary, 00 timer pin.
// RULE_08: serial select: 10/11 sub-main, 01 auxiliary, 00 serial pin.
// RULE_09: watchdog select: 00 sub-main, 01 auxiliary, 10 low-power clock.
// RULE_10: converter select: 10/11 sub-main, 01 auxiliary, 00 module osc.
// RULE_11: counter select: 01 sub or aux by alt bit, 11 low-power, 10 crystal.
// RULE_12: crystal is main code 10, auxiliary and reference code 0.
// RULE_13: main up to 16 MHz, aux 40 kHz, module 4 MHz, low-power 10 kHz.
// RULE_14: source and divider switching never makes a short pulse.
// RULE_15: reserved select codes give no clock, never an undefined one.
package cssd_pkg;
  localparam int CLK_MHZ = 200;
  // crystal silent this long counts as failed
  localparam int XT_TIMEOUT_US = 100;
  localparam int XT_TIMEOUT_CYC = XT_TIMEOUT_US * CLK_MHZ;
  // nominal rates, for reference only [RULE_13]
  localparam int MAIN_MAX_KHZ = 16000;
  localparam int AUX_MAX_KHZ = 40;
  localparam int MOD_KHZ = 4000;
  localparam int VLP_KHZ = 10;

  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PSEL = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQ = 5'h0c;
  localparam logic [4:0] OFS_MASK = 5'h10;

  // oscillator pin indices
  localparam int PIN_DCO = 0;
  localparam int PIN_RC = 1;
  localparam int PIN_XT = 2;
  localparam int PIN_VLP = 3;
  localparam int PIN_MOD = 4;
  localparam int PIN_TMR = 5;
  localparam int PIN_SER = 6;
  localparam int NPIN = 7;

  // channel muxes
  localparam int CH_MAIN = 0;
  localparam int CH_AUX = 1;
  localparam int CH_REF = 2;
  localparam int CH_TMR = 3;
  localparam int CH_SER = 4;
  localparam int CH_WDT = 5;
  localparam int CH_CONV = 6;
  localparam int CH_CNT = 7;
  localparam int NCH = 8;
  localparam int NSRC = 5;
  localparam int SW = 3;

  localparam logic [1:0] MSEL_DCO = 2'h0;
  localparam logic [1:0] MSEL_RC = 2'h1;
  localparam logic [1:0] MSEL_XT = 2'h2; // [RULE_12]
  localparam logic [1:0] MSEL_VLP = 2'h3;
  localparam logic [SW-1:0] IDX_XT = 3'h0;
  localparam logic [SW-1:0] IDX_RC = 3'h1;
  localparam logic [SW-1:0] IDX_CNT_AUX = 3'h4;

  localparam int IRQ_FAULT = 0;
  localparam int IRQ_SWITCH = 1;
  localparam int IRQ_W = 2;

  localparam int MDIV_W = 3;
  localparam int SDIV_W = 2;
  localparam int CTRL_W = 9;
  localparam int PSEL_W = 11;

  typedef struct packed {
    logic ref_sel;
    logic aux_sel;
    logic [SDIV_W-1:0] sub_div;
    logic [MDIV_W-1:0] main_div;
    logic [1:0] main_sel;
  } cssd_ctrl_t;

  typedef struct packed {
    logic cnt_alt;
    logic [1:0] cnt;
    logic [1:0] conv;
    logic [1:0] wdt;
    logic [1:0] ser;
    logic [1:0] tmr;
  } cssd_psel_t;

  localparam cssd_ctrl_t CTRL_RST = 9'h180;
  localparam cssd_psel_t PSEL_RST = 11'h000;

  typedef enum logic [1:0] {
    GM_RUN = 2'b01,
    GM_PARK = 2'b10
  } cssd_gm_state_t;
endpackage : cssd_pkg

// [cssd_glitch_mux.sv]
// glitch-free clock selector working on sampled clock levels
`timescale 1ns/1ps
module cssd_glitch_mux #(
  parameter int NSRC = 5,
  parameter int SW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [NSRC-1:0] src_i,
  input wire logic [SW-1:0] sel_i,
  output logic clk_o,
  output logic switched_o
);
  cssd_pkg::cssd_gm_state_t state_reg, state_next;
  logic [SW-1:0] cur_reg, cur_next;
  logic out_reg, out_next;
  logic sw_reg, sw_next;

  // leave the old source only while it is low, join the new one while low
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    out_next = 1'b0;
    sw_next = 1'b0;
    case (state_reg)
      cssd_pkg::GM_RUN: begin
        if (sel_i != cur_reg && !src_i[cur_reg]) begin
          state_next = cssd_pkg::GM_PARK; // [RULE_14]
        end else begin
          out_next = src_i[cur_reg];
        end
      end
      cssd_pkg::GM_PARK: begin
        if (!src_i[sel_i]) begin
          cur_next = sel_i;
          state_next = cssd_pkg::GM_RUN;
          sw_next = 1'b1;
        end
      end
      default: state_next = cssd_pkg::GM_PARK;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= cssd_pkg::GM_RUN;
      cur_reg <= '0;
      out_reg <= 1'b0;
      sw_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      out_reg <= out_next;
      sw_reg <= sw_next;
    end
  end

  assign clk_o = out_reg;
  assign switched_o = sw_reg;

  property p_park_low;
    @(posedge clk_i) disable iff (rst_i)
    state_reg == cssd_pkg::GM_PARK |=> !out_reg;
  endproperty
  a_park_low: assert property (p_park_low) // [RULE_14]
    else $error("clock not held low while switching");
endmodule : cssd_glitch_mux

// [cssd_divider.sv]
// power-of-two divider of a sampled clock level
`timescale 1ns/1ps
module cssd_divider #(
  parameter int KW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic src_i,
  input wire logic [KW-1:0] exp_i,
  output logic clk_o
);
  localparam int CW = (1 << KW) - 1;
  logic prev_reg, prev_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [KW-1:0] k_reg, k_next;
  logic out_reg, out_next;
  logic [CW-1:0] mask;

  // a new ratio only lands at a period boundary, output then low, or high at ratio 1 where the source passes straight through
  always_comb begin
    mask = CW'((1 << k_reg) - 1);
    prev_next = src_i;
    cnt_next = cnt_reg;
    k_next = k_reg;
    if (src_i && !prev_reg) begin
      if (cnt_reg == mask) begin
        cnt_next = '0;
        k_next = exp_i; // [RULE_14]
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
    if (k_next == '0) begin
      out_next = src_i;
    end else begin
      out_next = cnt_next[k_next - KW'(1)];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
      cnt_reg <= '0;
      k_reg <= '0;
      out_reg <= 1'b0;
    end else if (ce_i) begin
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
      k_reg <= k_next;
      out_reg <= out_next;
    end
  end

  assign clk_o = out_reg;
endmodule : cssd_divider

// [cssd_top.sv]
// clock source selection, division and distribution with wishbone regs
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module cssd_top #(
  parameter int FAULT_CYC = cssd_pkg::XT_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic digitally_controlled_osc_i,
  input wire logic internal_rc_32k_osc_i,
  input wire logic crystal_clock_i,
  input wire logic very_low_power_clock_i,
  input wire logic module_osc_clock_i,
  input wire logic timer_ext_clock_pin_i,
  input wire logic serial_ext_clock_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic main_clock_o,
  output logic sub_main_clock_o,
  output logic aux_clock_o,
  output logic frequency_lock_loop_ref_o,
  output logic timer_clock_o,
  output logic serial_clock_o,
  output logic watchdog_clock_o,
  output logic converter_clock_o,
  output logic counter_clock_o,
  output logic irq_o
);
  localparam int FW = $clog2(FAULT_CYC + 1);
  localparam int NP = cssd_pkg::NPIN;
  localparam int NCH = cssd_pkg::NCH;
  localparam int NSRC = cssd_pkg::NSRC;
  localparam int SW = cssd_pkg::SW;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  logic [NP-1:0] pin_vec, meta_reg, sync_reg;

  assign pin_vec = {serial_ext_clock_pin_i, timer_ext_clock_pin_i,
                    module_osc_clock_i, very_low_power_clock_i,
                    crystal_clock_i, internal_rc_32k_osc_i,
                    digitally_controlled_osc_i};

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= pin_vec;
      sync_reg <= meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crystal fail-safe watch
  logic xt_prev_reg, xt_prev_next;
  logic [FW-1:0] fault_cnt_reg, fault_cnt_next;
  logic xt_fault_reg, xt_fault_next;

  always_comb begin
    xt_prev_next = sync_reg[cssd_pkg::PIN_XT];
    fault_cnt_next = fault_cnt_reg;
    xt_fault_next = xt_fault_reg;
    if (xt_prev_next != xt_prev_reg) begin
      fault_cnt_next = '0;
      xt_fault_next = 1'b0;
    end else if (fault_cnt_reg == FW'(FAULT_CYC - 1)) begin
      xt_fault_next = 1'b1; // [RULE_05]
    end else begin
      fault_cnt_next = fault_cnt_reg + FW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xt_prev_reg <= 1'b0;
      fault_cnt_reg <= '0;
      xt_fault_reg <= 1'b0;
    end else if (ce_i) begin
      xt_prev_reg <= xt_prev_next;
      fault_cnt_reg <= fault_cnt_next;
      xt_fault_reg <= xt_fault_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and wishbone slave
  cssd_pkg::cssd_ctrl_t ctrl_reg, ctrl_next;
  cssd_pkg::cssd_psel_t psel_reg, psel_next;
  logic [cssd_pkg::IRQ_W-1:0] stat_reg, stat_next;
  logic [cssd_pkg::IRQ_W-1:0] mask_reg, mask_next;
  logic [cssd_pkg::IRQ_W-1:0] events;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic irq_reg, irq_next;
  logic [31:0] wmask, m_ctrl, m_psel, m_mask;
  logic wr;
  logic [NCH-1:0] ch_clk, ch_sw;

  always_comb begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // writes land on the edge where the master sees ack
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
    ack_next = wb_cyc_i & wb_stb_i & !ack_reg;
    m_ctrl = (32'(ctrl_reg) & ~wmask) | (wb_dat_i & wmask);
    m_psel = (32'(psel_reg) & ~wmask) | (wb_dat_i & wmask);
    m_mask = (32'(mask_reg) & ~wmask) | (wb_dat_i & wmask);
    ctrl_next = ctrl_reg;
    psel_next = psel_reg;
    mask_next = mask_reg;
    events = '0;
    events[cssd_pkg::IRQ_FAULT] = xt_fault_next & !xt_fault_reg;
    events[cssd_pkg::IRQ_SWITCH] = ch_sw[cssd_pkg::CH_MAIN];
    stat_next = stat_reg;
    if (wr) begin
      case (wb_adr_i)
        cssd_pkg::OFS_CTRL:
          ctrl_next = cssd_pkg::cssd_ctrl_t'(m_ctrl[cssd_pkg::CTRL_W-1:0]);
        cssd_pkg::OFS_PSEL:
          psel_next = cssd_pkg::cssd_psel_t'(m_psel[cssd_pkg::PSEL_W-1:0]);
        cssd_pkg::OFS_MASK: mask_next = m_mask[cssd_pkg::IRQ_W-1:0];
        cssd_pkg::OFS_IRQ:
          stat_next = stat_reg & ~(wb_dat_i[cssd_pkg::IRQ_W-1:0] &
                                   wmask[cssd_pkg::IRQ_W-1:0]);
        default: ;
      endcase
    end
    // a fresh event beats a clear in the same cycle
    stat_next = stat_next | events;
    irq_next = |(stat_reg & mask_reg);
    dat_next = dat_reg;
    if (ack_next) begin
      case (wb_adr_i)
        cssd_pkg::OFS_CTRL: dat_next = 32'(ctrl_reg);
        cssd_pkg::OFS_PSEL: dat_next = 32'(psel_reg);
        cssd_pkg::OFS_STAT:
          dat_next = {29'h0, sub_main_clock_o, main_clock_o, xt_fault_reg};
        cssd_pkg::OFS_IRQ: dat_next = 32'(stat_reg);
        cssd_pkg::OFS_MASK: dat_next = 32'(mask_reg);
        default: dat_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= cssd_pkg::CTRL_RST;
      psel_reg <= cssd_pkg::PSEL_RST;
      stat_reg <= '0;
      mask_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      ctrl_reg <= ctrl_next;
      psel_reg <= psel_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      irq_reg <= irq_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // source tables and selections per channel
  logic [NCH-1:0][NSRC-1:0] ch_src;
  logic [NCH-1:0][SW-1:0] ch_sel;
  logic digitally_controlled_osc, rc, xt, vlp, modc, tpin, spin, sub, aux;

  always_comb begin
    digitally_controlled_osc = sync_reg[cssd_pkg::PIN_DCO];
    rc = sync_reg[cssd_pkg::PIN_RC];
    // a crystal stuck high would pin a selector on it; dead reads low
    xt = sync_reg[cssd_pkg::PIN_XT] & !xt_fault_reg; // [RULE_05]
    vlp = sync_reg[cssd_pkg::PIN_VLP];
    modc = sync_reg[cssd_pkg::PIN_MOD];
    tpin = sync_reg[cssd_pkg::PIN_TMR];
    spin = sync_reg[cssd_pkg::PIN_SER];
    sub = sub_main_clock_o;
    aux = aux_clock_o;
    // module oscillator is absent from the main table [RULE_01]
    ch_src[cssd_pkg::CH_MAIN] = {1'b0, vlp, xt, rc, digitally_controlled_osc};
    ch_sel[cssd_pkg::CH_MAIN] = {1'b0, ctrl_reg.main_sel};
    if (xt_fault_reg && ctrl_reg.main_sel == cssd_pkg::MSEL_XT) begin
      ch_sel[cssd_pkg::CH_MAIN] = cssd_pkg::IDX_RC; // [RULE_05]
    end
    ch_src[cssd_pkg::CH_AUX] = {3'h0, rc, xt}; // [RULE_03]
    ch_sel[cssd_pkg::CH_AUX] = (ctrl_reg.aux_sel || xt_fault_reg) ?
                               cssd_pkg::IDX_RC : cssd_pkg::IDX_XT;
    ch_src[cssd_pkg::CH_REF] = {3'h0, rc, xt}; // [RULE_04] [RULE_12]
    ch_sel[cssd_pkg::CH_REF] = (ctrl_reg.ref_sel || xt_fault_reg) ?
                               cssd_pkg::IDX_RC : cssd_pkg::IDX_XT;
    // code 11 reaches a tied-low input [RULE_07] [RULE_15]
    ch_src[cssd_pkg::CH_TMR] = {2'h0, sub, aux, tpin};
    ch_sel[cssd_pkg::CH_TMR] = {1'b0, psel_reg.tmr};
    ch_src[cssd_pkg::CH_SER] = {2'h0, sub, aux, spin}; // [RULE_08]
    ch_sel[cssd_pkg::CH_SER] = psel_reg.ser[1] ? 3'h2 : {1'b0, psel_reg.ser};
    ch_src[cssd_pkg::CH_WDT] = {2'h0, vlp, aux, sub}; // [RULE_09] [RULE_15]
    ch_sel[cssd_pkg::CH_WDT] = {1'b0, psel_reg.wdt};
    ch_src[cssd_pkg::CH_CONV] = {2'h0, sub, aux, modc}; // [RULE_10]
    ch_sel[cssd_pkg::CH_CONV] =
      psel_reg.conv[1] ? 3'h2 : {1'b0, psel_reg.conv};
    // alt bit picks a distinct input, so changing it is also glitch-free
    ch_src[cssd_pkg::CH_CNT] = {aux, vlp, xt, sub, 1'b0}; // [RULE_11]
    ch_sel[cssd_pkg::CH_CNT] = {1'b0, psel_reg.cnt};
    if (psel_reg.cnt == 2'h1 && psel_reg.cnt_alt) begin
      ch_sel[cssd_pkg::CH_CNT] = cssd_pkg::IDX_CNT_AUX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // glitch-free selectors and dividers
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      cssd_glitch_mux #(.NSRC(NSRC), .SW(SW)) u_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .src_i(ch_src[g]),
        .sel_i(ch_sel[g]),
        .clk_o(ch_clk[g]),
        .switched_o(ch_sw[g])
      );
    end
  endgenerate

  // main clock feeds cpu, memories, checksum and ports directly [RULE_06]
  cssd_divider #(.KW(cssd_pkg::MDIV_W)) u_main_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .src_i(ch_clk[cssd_pkg::CH_MAIN]),
    .exp_i(ctrl_reg.main_div), // [RULE_01]
    .clk_o(main_clock_o)
  );

  // sub-main only ever divides the main clock [RULE_02]
  cssd_divider #(.KW(cssd_pkg::SDIV_W)) u_sub_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .src_i(main_clock_o),
    .exp_i(ctrl_reg.sub_div),
    .clk_o(sub_main_clock_o)
  );

  assign aux_clock_o = ch_clk[cssd_pkg::CH_AUX];
  assign frequency_lock_loop_ref_o = ch_clk[cssd_pkg::CH_REF];
  assign timer_clock_o = ch_clk[cssd_pkg::CH_TMR];
  assign serial_clock_o = ch_clk[cssd_pkg::CH_SER];
  assign watchdog_clock_o = ch_clk[cssd_pkg::CH_WDT];
  assign converter_clock_o = ch_clk[cssd_pkg::CH_CONV];
  assign counter_clock_o = ch_clk[cssd_pkg::CH_CNT];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_main_src;
    !xt_fault_reg |-> ch_sel[cssd_pkg::CH_MAIN] == {1'b0, ctrl_reg.main_sel};
  endproperty
  a_main_src: assert property (p_main_src) // [RULE_01]
    else $error("main selector does not follow its field");

  property p_failsafe;
    xt_fault_reg && ctrl_reg.main_sel == cssd_pkg::MSEL_XT
      |-> ch_sel[cssd_pkg::CH_MAIN] == cssd_pkg::IDX_RC;
  endproperty
  a_failsafe: assert property (p_failsafe) // [RULE_05]
    else $error("failed crystal still drives main clock");

  property p_fault_time;
    $rose(xt_fault_reg) |-> $past(fault_cnt_reg) == FW'(FAULT_CYC - 1);
  endproperty
  a_fault_time: assert property (p_fault_time) // [RULE_05]
    else $error("crystal fault flagged at wrong time");

  property p_sub_follow;
    $rose(sub_main_clock_o) |-> $past(main_clock_o) && !$past(main_clock_o, 2);
  endproperty
  a_sub_follow: assert property (p_sub_follow) // [RULE_02]
    else $error("sub-main edge without main clock edge");

  property p_aux_src;
    !xt_fault_reg && !ctrl_reg.aux_sel |-> ch_sel[cssd_pkg::CH_AUX] == 3'h0;
  endproperty
  a_aux_src: assert property (p_aux_src) // [RULE_03] [RULE_12]
    else $error("aux does not take crystal on code 0");

  property p_ref_src;
    ctrl_reg.ref_sel |-> ch_sel[cssd_pkg::CH_REF] == cssd_pkg::IDX_RC;
  endproperty
  a_ref_src: assert property (p_ref_src) // [RULE_04]
    else $error("reference does not take rc oscillator");

  property p_tmr_sub;
    psel_reg.tmr == 2'h2 |-> ch_src[cssd_pkg::CH_TMR][ch_sel[cssd_pkg::CH_TMR]]
      == sub_main_clock_o;
  endproperty
  a_tmr_sub: assert property (p_tmr_sub) // [RULE_07]
    else $error("timer code 10 not on sub-main");

  property p_ser_sub;
    psel_reg.ser[1] |-> ch_sel[cssd_pkg::CH_SER] == 3'h2;
  endproperty
  a_ser_sub: assert property (p_ser_sub) // [RULE_08]
    else $error("serial code 1x not on sub-main");

  property p_wdt_vlp;
    psel_reg.wdt == 2'h2 |-> ch_src[cssd_pkg::CH_WDT][ch_sel[cssd_pkg::CH_WDT]]
      == sync_reg[cssd_pkg::PIN_VLP];
  endproperty
  a_wdt_vlp: assert property (p_wdt_vlp) // [RULE_09]
    else $error("watchdog code 10 not on low-power clock");

  property p_conv_mod;
    psel_reg.conv == 2'h0
      |-> ch_src[cssd_pkg::CH_CONV][ch_sel[cssd_pkg::CH_CONV]]
      == sync_reg[cssd_pkg::PIN_MOD];
  endproperty
  a_conv_mod: assert property (p_conv_mod) // [RULE_10]
    else $error("converter code 00 not on module oscillator");

  property p_cnt_alt;
    psel_reg.cnt == 2'h1 && psel_reg.cnt_alt
      |-> ch_src[cssd_pkg::CH_CNT][ch_sel[cssd_pkg::CH_CNT]] == aux_clock_o;
  endproperty
  a_cnt_alt: assert property (p_cnt_alt) // [RULE_11]
    else $error("counter alt bit does not pick aux");

  property p_rsv_quiet;
    psel_reg.wdt == 2'h3 |->
      !ch_src[cssd_pkg::CH_WDT][ch_sel[cssd_pkg::CH_WDT]];
  endproperty
  a_rsv_quiet: assert property (p_rsv_quiet) // [RULE_15]
    else $error("reserved watchdog code selects a clock");

  property p_irq;
    ce_i |=> irq_o == $past(|(stat_reg & mask_reg));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output out of step");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held two cycles");

  c_fault: cover property ($rose(xt_fault_reg));
  c_main_switch: cover property (ch_sw[cssd_pkg::CH_MAIN]);
  c_wb_write: cover property (wr);
  c_cnt_aux: cover property (psel_reg.cnt == 2'h1 && psel_reg.cnt_alt);
endmodule : cssd_top

// [cssd_consumer.sv]
// clock consumer model: period and shortest pulse of every clock output
`timescale 1ns/1ps
module cssd_consumer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [8:0] clks_i,
  output logic [8:0][11:0] period_o,
  output logic [11:0] min_pulse_o
);
  logic [8:0] last_reg;
  logic [8:0][11:0] since_reg;
  logic [8:0][11:0] run_reg;
  ////////////////////////////////////////////////////////////////////////////
  // a silent clock reads as period 0 once far past the longest legal one
  always @(posedge clk_i) begin
    last_reg <= clks_i;
    if (rst_i) min_pulse_o <= 12'hfff;
    for (int i = 0; i < 9; i++) begin
      if (rst_i) begin
        since_reg[i] <= '0;
        run_reg[i] <= '0;
        period_o[i] <= '0;
      end else begin
        since_reg[i] <= since_reg[i] + 12'(since_reg[i] < 12'hfff);
        run_reg[i] <= run_reg[i] + 12'(run_reg[i] < 12'hfff);
        if (clks_i[i] != last_reg[i]) begin
          run_reg[i] <= 12'h001;
          if (run_reg[i] < min_pulse_o) min_pulse_o <= run_reg[i];
        end
        if (clks_i[i] && !last_reg[i]) begin
          since_reg[i] <= 12'h001;
          period_o[i] <= since_reg[i];
        end else if (since_reg[i] == 12'h9c4) period_o[i] <= '0;
      end
    end
  end
endmodule : cssd_consumer

// [cssd_top_test.sv]
// self-checking bench of the clock select and division block
`timescale 1ns/1ps
module cssd_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic xt_run = 1'b1;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat, q;
  logic [6:0] src = 7'h00;
  logic [8:0] ck;
  logic [8:0] c;
  logic [10:0] p;
  logic ack, irq;
  logic [8:0][11:0] per;
  logic [11:0] minp;
  int half[7] = '{2, 5, 7, 9, 3, 4, 6};
  int cnt[7] = '{default: 0};
  int num_errors = 0;
  int compares = 0;

  cssd_top #(.FAULT_CYC(40)) cssd_top_inst (
    .clk_i(clk), .rst_i(rst), .ce_i(1'b1),
    .digitally_controlled_osc_i(src[0]), .internal_rc_32k_osc_i(src[1]),
    .crystal_clock_i(src[2]), .very_low_power_clock_i(src[3]),
    .module_osc_clock_i(src[4]), .timer_ext_clock_pin_i(src[5]),
    .serial_ext_clock_pin_i(src[6]), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .main_clock_o(ck[0]),
    .sub_main_clock_o(ck[1]), .aux_clock_o(ck[2]),
    .frequency_lock_loop_ref_o(ck[3]), .timer_clock_o(ck[4]),
    .serial_clock_o(ck[5]), .watchdog_clock_o(ck[6]),
    .converter_clock_o(ck[7]), .counter_clock_o(ck[8]), .irq_o(irq));
  cssd_consumer cssd_consumer_inst (.clk_i(clk), .rst_i(rst), .clks_i(ck),
    .period_o(per), .min_pulse_o(minp));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clk = ~clk;
  end
  // oscillators as sampled levels; the crystal can be stopped
  always @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      cnt[i] <= (cnt[i] >= half[i] - 1) ? 0 : cnt[i] + 1;
      if (cnt[i] >= half[i] - 1 && (i != 2 || xt_run)) src[i] <= ~src[i];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, e, input string n);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // request held until ack is seen high at a rising edge, then released
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) num_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // expected period in cycles from the select and divider fields
  function automatic int ep(int ch, logic [8:0] c, logic [10:0] p);
    int m[4];
    int mn, sb, ax;
    m = '{4, 10, 14, 18};
    mn = m[c[1:0]] << c[4:2];
    sb = mn << c[6:5];
    ax = c[7] ? 10 : 14;
    case (ch)
      0: return mn;
      1: return sb;
      2: return ax;
      3: return c[8] ? 10 : 14;
      4: return p[1:0] == 2 ? sb : p[1:0] == 1 ? ax : p[1:0] == 0 ? 8 : 0;
      5: return p[3] ? sb : p[2] ? ax : 12;
      6: return p[5:4] == 0 ? sb : p[5:4] == 1 ? ax : p[5:4] == 2 ? 18 : 0;
      7: return p[7] ? sb : p[6] ? ax : 6;
      default: return p[9:8] == 1 ? (p[10] ? ax : sb) :
        p[9:8] == 2 ? 14 : p[9:8] == 3 ? 18 : 0;
    endcase
  endfunction : ep
  task automatic end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h29a3ab21));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(0, 5'h00, 0);
    chk(q, 32'h180, "ctrl reset");
    wb(0, 5'h10, 0);
    chk(q, 0, "mask reset");
    // every code of main_sel and of the five peripheral select fields is visited in the first four passes
    for (int k = 0; k < 12; k++) begin
      c = 9'($urandom) & 9'h1ec;
      c[1:0] = 2'(k) ^ 2'(k >> 2);
      p = {1'($urandom), {5{2'(k)}}};
      wb(1, 5'h00, 32'(c));
      wb(1, 5'h04, 32'(p));
      wb(0, 5'h04, 0);
      chk(q, 32'(p), "psel");
      repeat (5000) @(negedge clk);
      for (int i = 0; i < 4; i++)
        chk(per[i], ep(i, c, p), "period");
      for (int i = 4; i < 9; i++)
        chk(per[i], ep(i, c, p), "period");
    end
    wb(1, 5'h00, 32'h002);
    wb(1, 5'h10, 32'h1);
    xt_run <= 1'b0;
    repeat (400) @(negedge clk);
    chk(32'(irq), 1, "irq");
    chk(per[0], 10, "fallback");
    wb(0, 5'h08, 0);
    chk(q & 1, 1, "fault");
    wb(1, 5'h10, 0);
    repeat (3) @(negedge clk);
    chk(32'(irq), 0, "masked");
    xt_run <= 1'b1;
    repeat (400) @(negedge clk);
    wb(1, 5'h0c, 32'h3);
    wb(0, 5'h0c, 0);
    chk(q & 1, 0, "cleared");
    chk(per[0], 14, "crystal");
    wb(0, 5'h14, 0);
    chk(q, 0, "unmapped");
    chk(32'(minp >= 2), 1, "pulse");
    end_sim;
  end
endmodule : cssd_top_test
